// ===== logic/slot_supply_limiter_regs.sv
// apb register bank for sample width, slot choice, supply readout and limiter setup
//
// Our own choice: the APB interface to the registers.
module slot_supply_limiter_regs
  import slot_limiter_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] supply_code_in,
  input wire logic [1:0] strap_slot_level,
  output logic sample_width_16,
  output logic [3:0] active_slot,
  output logic [1:0] limiter_release_rate,
  output logic [1:0] limiter_attack_rate,
  output logic [4:0] limiter_threshold_code,
  output logic limiter_engage,
  output logic output_mute
);

  typedef struct packed {
    logic [7:0] slot_cfg;
    logic [7:0] supply;
    logic [7:0] lim_rate;
    logic [7:0] lim_thr;
    logic [7:0] inflect;
    logic [DATA_W-1:0] rdata;
    logic ready;
    logic err;
    logic width16;
    logic [3:0] slot;
    logic [1:0] release_rate;
    logic [1:0] attack_rate;
    logic [4:0] thr;
    logic engage;
    logic mute;
  } regs_state_type;

  localparam regs_state_type STATE_RESET = '{
    slot_cfg: RST_SLOT_CFG,
    supply: RST_SUPPLY,
    lim_rate: RST_LIM_RATE,
    lim_thr: RST_LIM_THR,
    inflect: RST_INFLECT,
    rdata: '0,
    ready: 1'b0,
    err: 1'b0,
    width16: RST_SLOT_CFG[POS_WIDTH16],
    slot: RST_SLOT_CFG[POS_SLOT_LSB +: 4],
    release_rate: RST_LIM_RATE[POS_RELEASE_LSB +: 2],
    attack_rate: RST_LIM_RATE[POS_ATTACK_LSB +: 2],
    thr: RST_LIM_THR[POS_THR_LSB +: 5],
    engage: 1'b0,
    mute: 1'b0
  };

  regs_state_type state_q;
  regs_state_type state_d;

  limiter_cfg_if cfg ();

  // word index of an aligned address, or all ones when misaligned
  function automatic logic [5:0] word_index(input logic [ADDR_W-1:0] addr);
    if (addr[1:0] != 2'b00) begin
      return 6'h3f;
    end
    return addr[ADDR_W-1:2];
  endfunction

  function automatic logic is_mapped(input logic [5:0] idx);
    return (idx == IDX_SLOT_CFG) || (idx == IDX_SUPPLY) || (idx == IDX_LIM_RATE) ||
      (idx == IDX_LIM_THR) || (idx == IDX_INFLECT);
  endfunction

  function automatic logic [7:0] read_byte(input regs_state_type s, input logic [5:0] idx);
    case (idx)
      IDX_SLOT_CFG: return s.slot_cfg;
      IDX_SUPPLY: return s.supply;
      IDX_LIM_RATE: return s.lim_rate;
      IDX_LIM_THR: return s.lim_thr;
      IDX_INFLECT: return s.inflect;
      default: return 8'h00;
    endcase
  endfunction

  logic [5:0] idx;
  logic setup_phase;
  logic access_done;
  logic below_inflection;
  limiter_mode_type mode;

  assign cfg.threshold_code = state_q.lim_thr[POS_THR_LSB +: 5];
  assign cfg.slope = state_q.lim_thr[POS_SLOPE_LSB +: 2];
  assign cfg.track = state_q.lim_rate[POS_TRACK];
  assign cfg.supply_code = state_q.supply;
  assign cfg.inflection = state_q.inflect;

  threshold_tracker u_tracker (
    .pclk(pclk),
    .presetn(presetn),
    .cfg(cfg)
  );

  always_comb begin
    state_d = state_q;
    idx = word_index(paddr);
    setup_phase = psel && !penable;
    access_done = psel && penable && state_q.ready;

    // answer is prepared in the setup cycle so the access phase needs no wait state
    state_d.ready = setup_phase;
    if (setup_phase) begin
      state_d.err = !is_mapped(idx);
      state_d.rdata = '0;
      if (!pwrite && is_mapped(idx)) begin
        state_d.rdata = {24'h000000, read_byte(state_q, idx)};
      end
    end else begin
      // answer stands only in the access cycle; cleared at its completing edge
      state_d.err = 1'b0;
      state_d.rdata = '0;
    end

    // writes land only at the completing edge; the supply code is not writable
    if (access_done && pwrite && !state_q.err) begin
      case (idx)
        IDX_SLOT_CFG: state_d.slot_cfg = pwdata[7:0];
        IDX_LIM_RATE: state_d.lim_rate = pwdata[7:0];
        IDX_LIM_THR: state_d.lim_thr = pwdata[7:0];
        IDX_INFLECT: state_d.inflect = pwdata[7:0];
        default: state_d.inflect = state_q.inflect;
      endcase
    end

    state_d.supply = supply_code_in;

    state_d.width16 = state_q.slot_cfg[POS_WIDTH16];
    if (state_q.slot_cfg[POS_SLOT_FROM_PIN]) begin
      state_d.slot = {2'b00, strap_slot_level};
    end else begin
      state_d.slot = state_q.slot_cfg[POS_SLOT_LSB +: 4];
    end

    state_d.release_rate = state_q.lim_rate[POS_RELEASE_LSB +: 2];
    state_d.attack_rate = state_q.lim_rate[POS_ATTACK_LSB +: 2];
    state_d.thr = cfg.tracked_threshold;

    below_inflection = state_q.supply < state_q.inflect;
    mode = limiter_mode_type'(state_q.lim_rate[POS_MODE_LSB +: 2]);
    case (mode)
      mode_off: begin
        state_d.engage = 1'b0;
        state_d.mute = 1'b0;
      end
      mode_always: begin
        state_d.engage = 1'b1;
        state_d.mute = 1'b0;
      end
      mode_mute_low: begin
        state_d.engage = 1'b0;
        state_d.mute = below_inflection;
      end
      mode_limit_low: begin
        state_d.engage = below_inflection;
        state_d.mute = 1'b0;
      end
      default: begin
        state_d.engage = 1'b0;
        state_d.mute = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign prdata = state_q.rdata;
  assign pready = state_q.ready;
  assign pslverr = state_q.err;
  assign sample_width_16 = state_q.width16;
  assign active_slot = state_q.slot;
  assign limiter_release_rate = state_q.release_rate;
  assign limiter_attack_rate = state_q.attack_rate;
  assign limiter_threshold_code = state_q.thr;
  assign limiter_engage = state_q.engage;
  assign output_mute = state_q.mute;

endmodule // slot_supply_limiter_regs

// ===== logic/slot_limiter_pkg.sv
// constants, field layout and types of the slot and supply limiter register group
package slot_limiter_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register indexes; byte address is four times the index
  localparam logic [5:0] IDX_SLOT_CFG = 6'h05;
  localparam logic [5:0] IDX_SUPPLY = 6'h06;
  localparam logic [5:0] IDX_LIM_RATE = 6'h07;
  localparam logic [5:0] IDX_LIM_THR = 6'h08;
  localparam logic [5:0] IDX_INFLECT = 6'h09;

  localparam logic [7:0] RST_SLOT_CFG = 8'h00;
  localparam logic [7:0] RST_SUPPLY = 8'h00;
  localparam logic [7:0] RST_LIM_RATE = 8'ha4;
  localparam logic [7:0] RST_LIM_THR = 8'h51;
  localparam logic [7:0] RST_INFLECT = 8'h22;

  // field positions
  localparam int POS_WIDTH16 = 7;
  localparam int POS_SLOT_FROM_PIN = 4;
  localparam int POS_SLOT_LSB = 0;
  localparam int POS_RELEASE_LSB = 6;
  localparam int POS_ATTACK_LSB = 4;
  localparam int POS_TRACK = 2;
  localparam int POS_MODE_LSB = 0;
  localparam int POS_THR_LSB = 3;
  localparam int POS_SLOPE_LSB = 0;

  // about 10.3 supply codes make one 0.5 V threshold step
  localparam logic [9:0] SUPPLY_CODES_PER_STEP = 10'h00a;
  localparam logic [4:0] THR_CODE_MAX = 5'h1f;

  typedef enum logic [1:0] {
    mode_off = 2'b00,
    mode_always = 2'b01,
    mode_mute_low = 2'b10,
    mode_limit_low = 2'b11
  } limiter_mode_type;

endpackage

// ===== logic/limiter_cfg_if.sv
// carrier between the register bank and the threshold tracker
interface limiter_cfg_if;
  logic [4:0] threshold_code;
  logic [1:0] slope;
  logic track;
  logic [7:0] supply_code;
  logic [7:0] inflection;
  logic [4:0] tracked_threshold;

  modport regs (output threshold_code, output slope, output track, output supply_code, output inflection,
    input tracked_threshold);
  modport tracker (input threshold_code, input slope, input track, input supply_code, input inflection,
    output tracked_threshold);
endinterface

// ===== logic/threshold_tracker.sv
// supply-tracking attack threshold computation
module threshold_tracker
  import slot_limiter_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  limiter_cfg_if.tracker cfg
);

  typedef struct packed {
    logic [4:0] thr;
  } tracker_state_type;

  tracker_state_type state_q;
  tracker_state_type state_d;

  logic [7:0] deficit;
  logic [9:0] scaled;
  logic [9:0] steps;
  logic [9:0] sum;

  always_comb begin
    state_d = state_q;
    deficit = 8'h00;
    if (cfg.track && (cfg.supply_code < cfg.inflection)) begin
      deficit = cfg.inflection - cfg.supply_code;
    end
    // ratio 1:1..4:1 is slope code plus one
    scaled = 10'({2'b00, deficit} * ({8'h00, cfg.slope} + 10'h001));
    steps = scaled / SUPPLY_CODES_PER_STEP;
    sum = {5'h00, cfg.threshold_code} + steps;
    // higher code is a lower voltage; saturate at the 1.0 V floor
    if (sum > {5'h00, THR_CODE_MAX}) begin
      state_d.thr = THR_CODE_MAX;
    end else begin
      state_d.thr = sum[4:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= '{thr: RST_LIM_THR[POS_THR_LSB +: 5]};
    end else begin
      state_q <= state_d;
    end
  end

  assign cfg.tracked_threshold = state_q.thr;

endmodule // threshold_tracker

// ===== bench/slot_supply_limiter_regs_asserts.sv
// port-level assertions for the slot and supply limiter register bank
module slot_supply_limiter_regs_asserts
  import slot_limiter_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] supply_code_in,
  input wire logic [1:0] strap_slot_level,
  input wire logic sample_width_16,
  input wire logic [3:0] active_slot,
  input wire logic [1:0] limiter_release_rate,
  input wire logic [1:0] limiter_attack_rate,
  input wire logic [4:0] limiter_threshold_code,
  input wire logic limiter_engage,
  input wire logic output_mute
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable && pready;
  wire wr_slot = acc && pwrite && paddr == 8'h14;
  AST_WIDTH16: assert property (wr_slot |-> ##2 sample_width_16 == $past(pwdata[7], 2))
    else $error("sample width wrong");
  AST_SLOT_PIN: assert property (wr_slot && pwdata[4] |-> ##2 active_slot == {2'h0, $past(strap_slot_level)})
    else $error("strap slot wrong");
  AST_SLOT_FIELD: assert property (wr_slot && !pwdata[4] |-> ##2 active_slot == $past(pwdata[3:0], 2))
    else $error("slot field wrong");
  AST_SUPPLY: assert property (acc && !pwrite && paddr == 8'h18 |-> prdata == {24'h0, $past(supply_code_in, 2)})
    else $error("supply readout wrong");
  AST_RATES: assert property (acc && pwrite && paddr == 8'h1c |->
    ##2 {limiter_release_rate, limiter_attack_rate} == $past(pwdata[7:4], 2)) else $error("rates wrong");
  AST_PREADY_ONE: assert property (pready |=> !pready) else $error("pready too long");
  AST_PREADY_SETUP: assert property (psel && !penable |=> pready) else $error("no answer");
  AST_UNMAPPED: assert property (acc && (paddr[1:0] != 2'h0 || paddr < 8'h14 || paddr > 8'h24) |-> pslverr)
    else $error("missing error");
  AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0 && !pslverr) else $error("idle data not zero");
endmodule // slot_supply_limiter_regs_asserts

// ===== bench/test_slot_supply_limiter_regs.sv
// self-checking bench for the slot and supply limiter register bank
module test_slot_supply_limiter_regs
  import slot_limiter_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, sample_width_16, limiter_engage, output_mute;
  logic [7:0] supply_code_in = 8'h00;
  logic [1:0] strap_slot_level = 2'h0, limiter_release_rate, limiter_attack_rate;
  logic [3:0] active_slot;
  logic [4:0] limiter_threshold_code;
  int mismatches = 0, compares = 0, seed = 43482, i, v;
  int mdl [5:9];
  always #25 pclk = ~pclk;
  slot_supply_limiter_regs DUT (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .supply_code_in(supply_code_in),
    .strap_slot_level(strap_slot_level),
    .sample_width_16(sample_width_16),
    .active_slot(active_slot),
    .limiter_release_rate(limiter_release_rate),
    .limiter_attack_rate(limiter_attack_rate),
    .limiter_threshold_code(limiter_threshold_code),
    .limiter_engage(limiter_engage),
    .output_mute(output_mute)
  );
  task automatic check(string what, int exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic apb(logic w, int a, int d);
    int n = 0;
    {psel, penable, pwrite} <= {2'b10, w};
    paddr <= a[7:0];
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) mismatches++;
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  task automatic rdchk(int k);
    mdl[6] = supply_code_in;
    apb(0, k * 4, 0);
    check("readback", mdl[k], rd);
  endtask
  // outputs settle within four cycles: one for the register, two through the tracker
  task automatic outs;
    int s, t, m, low;
    repeat (4) @(posedge pclk);
    s = mdl[5];
    m = mdl[7] & 3;
    low = supply_code_in < mdl[9];
    t = mdl[8] >> 3;
    if ((mdl[7] & 4) && low) t = t + (mdl[9] - supply_code_in) * ((mdl[8] & 3) + 1) / 10;
    check("width", s >> 7, sample_width_16);
    check("slot", (s & 16) ? strap_slot_level : s & 15, active_slot);
    check("rates", mdl[7] >> 4, {limiter_release_rate, limiter_attack_rate});
    check("threshold", t > 31 ? 31 : t, limiter_threshold_code);
    check("engage", m == 1 || (m == 3 && low), limiter_engage);
    check("mute", m == 2 && low, output_mute);
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // about 750 cycles of traffic expected; forty thousand leaves ample margin
  initial begin
    #2000000;
    mismatches++;
    conclude;
  end
  initial begin
    mdl = '{8'h00, 8'h00, 8'ha4, 8'h51, 8'h22};
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    outs;
    for (i = 5; i < 10; i++) rdchk(i);
    $display("reset test done");
    apb(1, 8'h18, 8'hff);
    check("ro no error", 0, er);
    rdchk(6);
    apb(0, 8'h28, 0);
    check("unmapped error", 1, er);
    check("unmapped data", 0, rd);
    apb(1, 8'h15, 8'h55);
    check("misaligned error", 1, er);
    rdchk(5);
    $display("refusal test done");
    // last four passes take the slot from the strap level
    for (v = 0; v < 20; v++) begin
      mdl[5] = v < 16 ? v | (v & 1) << 7 : 8'h10;
      strap_slot_level <= v[1:0];
      apb(1, 8'h14, mdl[5]);
      outs;
    end
    $display("slot test done");
    for (v = 0; v < 16; v++) begin
      mdl[7] = v & 7 | 8'h40;
      mdl[8] = $random(seed) & 8'hff;
      supply_code_in <= v[3] ? 8'h05 : 8'hf0;
      apb(1, 8'h1c, mdl[7]);
      apb(1, 8'h20, mdl[8]);
      outs;
    end
    $display("mode test done");
    repeat (40) begin
      i = 5 + {$random(seed)} % 5;
      v = $random(seed) & 8'hff;
      apb(1, i * 4, v);
      if (i != 6) mdl[i] = v;
      supply_code_in <= $random(seed);
      strap_slot_level <= $random(seed);
      outs;
      rdchk(i);
    end
    $display("random test done");
    conclude;
  end
endmodule // test_slot_supply_limiter_regs
bind slot_supply_limiter_regs slot_supply_limiter_regs_asserts chk (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .supply_code_in(supply_code_in),
  .strap_slot_level(strap_slot_level),
  .sample_width_16(sample_width_16),
  .active_slot(active_slot),
  .limiter_release_rate(limiter_release_rate),
  .limiter_attack_rate(limiter_attack_rate),
  .limiter_threshold_code(limiter_threshold_code),
  .limiter_engage(limiter_engage),
  .output_mute(output_mute)
);
